// [src/i2c_data_address_regs.sv]
// Notes on behaviour
// - Slave-match disable low enables own-address match and general call detection.
// - In free-data format the slave-match disable bit does nothing.
// - Three-bit rate code 000..111 selects SCL divider n from 0 to 7.
// - Rate selection in effect after reset is code 000.
// - Received serial bits assemble into the buffer byte aligned at the LSB.
// - Transmit bytes leave most significant bit first.
// - Address byte: bits 7..1 target address, bit 0 direction, 1 master receives.
// - An all-zero address byte goes out as a general call.
// - Any buffer read, or buffer write with strobe bit 0 set, releases the pending byte and starts the next.
// - Only hardware reset clears the buffer byte; soft reset keeps it.
// - Own-address bits 7..1 hold the address answered as slave.
// - Own-address bit 0 set selects free-data format without addressing.
// - In free-data format a master only transmits, a slave only receives.
`timescale 1ns/1ps
`default_nettype none

module i2c_data_address_regs
	import i2c_regs_pkg::*;
#(
	parameter int HALF_BASE  = SCL_HALF_CYC,
	parameter int FIFO_DEPTH = 8
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]    scl_sync;
		logic [1:0]    sda_sync;
		logic          scl_prev;
		logic          sda_prev;
		logic          aw_got;
		logic          w_got;
		logic [7:0]    aw_addr;
		logic [7:0]    w_byte;
		logic          w_en;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [1:0]    rresp;
		logic [7:0]    rbyte;
		logic          smd;
		logic [2:0]    rate;
		logic [6:0]    own_addr;
		logic          free_fmt;
		logic [7:0]    buf_byte;
		logic          master;
		logic          trx;
		logic          enable;
		logic          stop_req;
		logic          swres_armed;
		engine_state_t st;
		logic          phase;
		logic [3:0]    bitcnt;
		logic [7:0]    shreg;
		logic          sda_drv;
		logic          scl_drv;
		logic          scl_pin;
		logic          pending;
		logic          busy;
		logic          addr_phase;
		logic          addressed;
		logic          gcall;
		logic          last_bit;
	} state_t;

	state_t     s;
	state_t     n;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       tick;
	logic       tick_run;
	logic       is_tx;
	logic       match_en;
	logic       smp;
	logic       drv_evt;
	logic       drv_val;
	logic [7:0] new_sh;
	logic       fifo_push;
	logic       fifo_ready;
	logic       fifo_valid;
	logic       fifo_pop;
	logic [7:0] fifo_data;
	logic       wr_buf;
	logic       do_write;
	logic       release_req;
	logic       cmd_start;
	logic       soft_reset;

	// ----------------------------------------
	// Line events and bit timing helpers
	// ----------------------------------------
	// Only the second sync stage feeds any logic
	assign scl_s     = s.scl_sync[1];
	assign sda_s     = s.sda_sync[1];
	assign scl_rise  = scl_s && !s.scl_prev;
	assign scl_fall  = !scl_s && s.scl_prev;
	assign start_det = scl_s && s.scl_prev && !sda_s && s.sda_prev;
	assign stop_det  = scl_s && s.scl_prev && sda_s && !s.sda_prev;
	assign tick_run  = s.master && (s.st == E_START || s.st == E_BITS
		|| s.st == E_STOP);
	// Master paces bits from ticks, slave follows the line
	assign smp       = s.master ? (tick && s.phase && scl_s) : scl_rise;
	assign drv_evt   = s.master ? (tick && !s.phase) : scl_fall;
	assign is_tx     = s.addr_phase ? s.master : s.trx;
	assign match_en  = !s.smd && !s.free_fmt;
	assign new_sh    = {s.shreg[6:0], is_tx ? 1'b0 : sda_s};
	// Receiver acks unless an unaddressed slave is still on the address
	assign drv_val   = (s.bitcnt == ACK_SLOT)
		? (!is_tx && (!s.addr_phase || s.addressed))
		: (is_tx && !s.shreg[7]);

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	// Transmit bytes queue here; a full queue stalls the write response
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.in_valid  (fifo_push),
		.in_ready  (fifo_ready),
		.in_data   (s.w_byte),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	scl_tick_gen #(
		.CNT_W     (16),
		.HALF_BASE (HALF_BASE)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.run     (tick_run),
		.rate    (s.rate),
		.tick    (tick)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		n = s;
		fifo_pop = 1'b0;
		release_req = 1'b0;
		cmd_start = 1'b0;
		soft_reset = 1'b0;
		n.scl_sync = {s.scl_sync[0], scl_i};
		n.sda_sync = {s.sda_sync[0], sda_i};
		n.scl_prev = s.scl_sync[1];
		n.sda_prev = s.sda_sync[1];

		// Read channel: one-cycle answer, held until taken
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (arvalid && arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rbyte = '0;
			case (araddr)
				OFF_CONTROL_ONE:
				begin
					n.rbyte[CO_SMD] = s.smd;
					n.rbyte[CO_RATE +: RATE_W] = s.rate;
				end
				OFF_SHIFT_BUF:
				begin
					n.rbyte = s.buf_byte;
					release_req = 1'b1;
				end
				OFF_OWN_ADDRESS:
				begin
					n.rbyte[OA_ADDR +: 7] = s.own_addr;
					n.rbyte[OA_FREE] = s.free_fmt;
				end
				OFF_STATUS:
				begin
					n.rbyte[SR_MASTER] = s.master;
					n.rbyte[SR_TRX] = s.trx;
					n.rbyte[SR_BUSY] = s.busy;
					n.rbyte[SR_IDLE] = !s.pending;
					n.rbyte[SR_ADDRESSED] = s.addressed;
					n.rbyte[SR_GCALL] = s.gcall;
					n.rbyte[SR_LAST] = s.last_bit;
				end
				OFF_CONTROL_TWO:
					n.rresp = RESP_OKAY;
				default:
					n.rresp = RESP_SLVERR;
			endcase
		end

		// Write channels latch independently, then commit together
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		if (awvalid && awready)
		begin
			n.aw_got = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			n.w_got = 1'b1;
			n.w_byte = wdata[7:0];
			n.w_en = wstrb[0];
		end
		if (do_write)
		begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (s.aw_addr)
				OFF_CONTROL_ONE:
				if (s.w_en)
				begin
					n.smd = s.w_byte[CO_SMD];
					n.rate = s.w_byte[CO_RATE +: RATE_W];
				end
				OFF_SHIFT_BUF:
					release_req = release_req || s.w_en;
				OFF_OWN_ADDRESS:
				if (s.w_en)
				begin
					n.own_addr = s.w_byte[OA_ADDR +: 7];
					n.free_fmt = s.w_byte[OA_FREE];
				end
				OFF_CONTROL_TWO:
				if (s.w_en)
				begin
					n.master = s.w_byte[C2_MASTER];
					n.trx = s.w_byte[C2_TRX];
					n.enable = s.w_byte[C2_ENABLE];
					release_req = release_req || s.w_byte[C2_CLEAR];
					cmd_start = s.w_byte[C2_START] && !s.busy;
					if (!s.w_byte[C2_START] && s.busy && s.master)
						n.stop_req = 1'b1;
					// Two-step key keeps a stray write from resetting
					if (s.w_byte[C2_SWRES +: 2] == SWRES_ARM)
						n.swres_armed = 1'b1;
					else if (s.w_byte[C2_SWRES +: 2] == SWRES_FIRE)
					begin
						soft_reset = s.swres_armed;
						n.swres_armed = 1'b0;
					end
				end
				OFF_STATUS:
					n.bresp = RESP_OKAY;
				default:
					n.bresp = RESP_SLVERR;
			endcase
		end

		// Byte engine
		case (s.st)
			// Start may come in the same write that sets master and enable
			E_IDLE:
			if (cmd_start && n.master && n.enable)
			begin
				n.sda_drv = 1'b1;
				n.busy = 1'b1;
				n.phase = 1'b0;
				n.st = E_START;
				n.addr_phase = !s.free_fmt;
				if (s.free_fmt)
					n.trx = 1'b1;
			end
			E_START:
			if (tick)
			begin
				n.scl_drv = 1'b1;
				n.st = E_LOAD;
			end
			E_LOAD:
			if (!is_tx || fifo_valid)
			begin
				fifo_pop = is_tx;
				n.shreg = is_tx ? fifo_data : '0;
				if (s.master && s.addr_phase)
					n.trx = !fifo_data[DIR_BIT];
				n.bitcnt = '0;
				n.phase = 1'b0;
				n.st = E_BITS;
				if (!s.master)
				begin
					n.scl_drv = 1'b0;
					n.sda_drv = is_tx && !fifo_data[7];
				end
			end
			E_BITS:
			if (smp)
			begin
				if (s.master)
				begin
					n.scl_drv = 1'b1;
					n.phase = 1'b0;
				end
				if (s.bitcnt == ACK_SLOT)
				begin
					// SDA holds through the SCL fall; next drive event moves it
					n.last_bit = sda_s;
					if (!is_tx)
						n.buf_byte = s.shreg;
					if (!s.master && s.addr_phase && !s.addressed)
					begin
						n.sda_drv = 1'b0;
						n.st = E_IGNORE;
					end
					else
					begin
						n.pending = 1'b1;
						n.st = E_WAIT;
						n.addr_phase = 1'b0;
						if (!s.master && s.addr_phase)
							n.trx = s.shreg[DIR_BIT] && !s.gcall;
					end
				end
				else
				begin
					n.shreg = new_sh;
					n.bitcnt = s.bitcnt + 4'h1;
					if (!s.master && s.addr_phase && s.bitcnt == LAST_BIT)
					begin
						n.gcall = match_en && new_sh == GCALL_BYTE;
						n.addressed = match_en
							&& (new_sh[7:OA_ADDR] == s.own_addr
							|| new_sh == GCALL_BYTE);
					end
				end
			end
			else if (drv_evt)
			begin
				n.sda_drv = drv_val;
				if (s.master)
				begin
					n.scl_drv = 1'b0;
					n.phase = 1'b1;
				end
			end
			E_WAIT:
			begin
				// Slave stretches only once the master has pulled SCL low
				if (!s.master && scl_fall)
				begin
					n.scl_drv = 1'b1;
					n.sda_drv = 1'b0;
				end
				if (release_req)
				begin
					n.pending = 1'b0;
					n.st = E_LOAD;
				end
				else if (s.stop_req && s.master)
				begin
					n.pending = 1'b0;
					n.stop_req = 1'b0;
					n.sda_drv = 1'b1;
					n.phase = 1'b0;
					n.st = E_STOP;
				end
			end
			E_STOP:
			if (tick)
			begin
				if (!s.phase)
				begin
					n.scl_drv = 1'b0;
					n.phase = 1'b1;
				end
				else if (scl_s)
				begin
					n.sda_drv = 1'b0;
					n.st = E_IDLE;
				end
			end
			E_IGNORE:
				n.sda_drv = 1'b0;
			default:
				n.st = E_IDLE;
		endcase

		// Bus monitor; an enabled slave restarts on any start condition
		if (start_det)
			n.busy = 1'b1;
		if (stop_det)
		begin
			n.busy = 1'b0;
			n.stop_req = 1'b0;
			if (!s.master)
			begin
				n.st = E_IDLE;
				n.scl_drv = 1'b0;
				n.sda_drv = 1'b0;
				n.pending = 1'b0;
			end
		end
		else if (start_det && !s.master && s.enable)
		begin
			n.st = E_BITS;
			n.bitcnt = '0;
			n.shreg = '0;
			n.addr_phase = !s.free_fmt;
			n.trx = 1'b0;
			n.addressed = 1'b0;
			n.gcall = 1'b0;
			n.pending = 1'b0;
			n.scl_drv = 1'b0;
			n.sda_drv = 1'b0;
		end

		// Soft reset clears the engine but keeps the buffer byte
		if (soft_reset)
		begin
			n.st = E_IDLE;
			n.master = 1'b0;
			n.trx = 1'b0;
			n.enable = 1'b0;
			n.busy = 1'b0;
			n.pending = 1'b0;
			n.stop_req = 1'b0;
			n.scl_drv = 1'b0;
			n.sda_drv = 1'b0;
			n.addressed = 1'b0;
			n.gcall = 1'b0;
			n.addr_phase = 1'b0;
		end

		// SCL lets go one clock after SDA moves, so data has setup time
		n.scl_pin = n.scl_drv || s.scl_drv;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Hardware reset is the only path that clears the buffer byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.rate <= RATE_RESET;
			s.buf_byte <= BYTE_RESET;
		end
		else if (ce)
			s <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Buffer writes wait for FIFO room, which back-pressures the master
	assign wr_buf    = s.aw_addr == OFF_SHIFT_BUF && s.w_en;
	assign do_write  = s.aw_got && s.w_got && !s.bvalid
		&& (!wr_buf || fifo_ready);
	assign fifo_push = do_write && wr_buf;
	assign awready   = !s.aw_got;
	assign wready    = !s.w_got;
	assign bvalid    = s.bvalid;
	assign bresp     = s.bresp;
	assign arready   = !s.rvalid;
	assign rvalid    = s.rvalid;
	assign rresp     = s.rresp;
	assign rdata     = {24'h00_0000, s.rbyte};
	// Open-drain: pins only ever pull low
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = s.scl_pin;
	assign sda_oe    = s.sda_drv;

endmodule

`default_nettype wire

// [src/i2c_regs_pkg.sv]
`default_nettype none

package i2c_regs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS       = 10;
	localparam int SCL_HALF_NS  = 1250;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int RATE_STEPS   = 7;

	// ----------------------------------------
	// Register map and bus answers
	// ----------------------------------------
	localparam int         ADDR_W          = 8;
	localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFF_SHIFT_BUF   = 8'h04;
	localparam logic [7:0] OFF_OWN_ADDRESS = 8'h08;
	localparam logic [7:0] OFF_CONTROL_TWO = 8'h0C;
	localparam logic [7:0] OFF_STATUS      = 8'h10;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int         CO_SMD      = 3;
	localparam int         CO_RATE     = 0;
	localparam int         RATE_W      = 3;
	localparam int         OA_FREE     = 0;
	localparam int         OA_ADDR     = 1;
	localparam int         DIR_BIT     = 0;
	localparam int         C2_MASTER   = 7;
	localparam int         C2_TRX      = 6;
	localparam int         C2_START    = 5;
	localparam int         C2_CLEAR    = 4;
	localparam int         C2_ENABLE   = 3;
	localparam int         C2_SWRES    = 0;
	localparam int         SR_MASTER   = 7;
	localparam int         SR_TRX      = 6;
	localparam int         SR_BUSY     = 5;
	localparam int         SR_IDLE     = 4;
	localparam int         SR_ADDRESSED = 2;
	localparam int         SR_GCALL    = 1;
	localparam int         SR_LAST     = 0;
	localparam logic [1:0] SWRES_ARM   = 2'h2;
	localparam logic [1:0] SWRES_FIRE  = 2'h1;
	localparam logic [2:0] RATE_RESET  = 3'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [7:0] GCALL_BYTE  = 8'h00;
	localparam logic [3:0] LAST_BIT    = 4'h7;
	localparam logic [3:0] ACK_SLOT    = 4'h8;

	typedef enum logic [2:0] {
		E_IDLE,
		E_START,
		E_LOAD,
		E_BITS,
		E_WAIT,
		E_STOP,
		E_IGNORE
	} engine_state_t;

endpackage

`default_nettype wire

// [src/byte_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module byte_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("byte_fifo depth must be a power of two");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 count;
		logic                        out_valid;
		logic [WIDTH-1:0]            out_data;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t next_s;
	logic        push;
	logic        pop;

	// Output word is a register; refilled when empty or taken
	assign in_ready  = s.count != (AW + 1)'(DEPTH);
	assign out_valid = s.out_valid;
	assign out_data  = s.out_data;

	// Pointer, count and output stage update
	always_comb
	begin
		next_s = s;
		push = in_valid && in_ready;
		pop = (!s.out_valid || out_ready) && s.count != '0;
		if (out_ready)
			next_s.out_valid = 1'b0;
		if (pop)
		begin
			next_s.out_data = s.mem[s.rd];
			next_s.out_valid = 1'b1;
			next_s.rd = s.rd + 1'b1;
		end
		if (push)
		begin
			next_s.mem[s.wr] = in_data;
			next_s.wr = s.wr + 1'b1;
		end
		next_s.count = s.count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

endmodule

`default_nettype wire

// [src/scl_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module scl_tick_gen
#(
	parameter int CNT_W     = 16,
	parameter int HALF_BASE = 125
)
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [2:0] rate,
	output logic            tick
);
	generate
		if (HALF_BASE < 1 || (HALF_BASE << 7) >= (1 << CNT_W))
		begin : g_bad_base
			$error("scl_tick_gen half period does not fit counter");
		end
	endgenerate

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} tick_state_t;

	tick_state_t      s;
	tick_state_t      next_s;
	logic [CNT_W-1:0] limit;

	// Half period doubles with each rate step
	assign limit = CNT_W'(HALF_BASE) << rate;
	assign tick  = s.tick;

	// Counter restarts whenever the engine stops needing ticks
	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		if (!run)
			next_s.cnt = '0;
		else if (s.cnt >= limit - 1'b1)
		begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end
		else
			next_s.cnt = s.cnt + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

endmodule

`default_nettype wire

// [tb/i2c_data_address_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module i2c_data_address_regs_properties
	import i2c_regs_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic              scl_oe
);
	// ------------------------------
	// Bus and clock line checks
	// ------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Read side: answer, hold, refusal
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer missing");
	read_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data not held");
	read_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	read_busy_a: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
	unmapped_read_a: assert property (
		arvalid && arready && araddr > OFF_STATUS |=> rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	// Write side: buffer writes may stall on a full queue, so left out
	write_answer_a: assert property (
		awvalid && awready && wvalid && wready && awaddr != OFF_SHIFT_BUF
		|=> !awready && !wready ##1 bvalid)
		else $error("write answer timing wrong");
	resp_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	// Short divider still gives a low phase of two cycles
	scl_low_a: assert property ($rose(scl_oe) |=> scl_oe)
		else $error("clock low phase too short");
endmodule

`default_nettype wire

// [tb/i2c_bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_partner
(
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [7:0] tx_byte,
	output logic            pull,
	output logic [7:0]      rx_byte,
	output logic            rx_stb
);
	// ------------------------------
	// Far-side slave, acks every byte it receives
	// ------------------------------
	int         k       = 0;
	logic       first   = 1'b0;
	logic       reading = 1'b0;
	logic [7:0] sh      = 8'h00;

	initial
	begin
		pull   = 1'b0;
		rx_stb = 1'b0;
	end

	// Start and stop on the wires restart the count
	always @(negedge sda)
		if (scl)
		begin
			k       = 0;
			first   = 1'b1;
			reading = 1'b0;
		end

	always @(posedge sda)
		if (scl)
		begin
			k       = 0;
			reading = 1'b0;
			pull    = 1'b0;
		end

	// Shift in at the LSB, so the first bit ends at bit 7
	always @(posedge scl)
	begin
		k = k + 1;
		if (!reading && k < 9)
			sh = {sh[6:0], sda};
		rx_byte = sh;
		rx_stb  = !reading && k == 8;
	end

	// Change SDA only while SCL is low
	always @(negedge scl)
	begin
		rx_stb = 1'b0;
		if (k == 9)
		begin
			k       = 0;
			reading = !reading && first && sh[0];
			pull    = reading && !tx_byte[7];
			first   = 1'b0;
		end
		else if (reading)
			pull = k < 8 && !tx_byte[3'(7 - k)];
		else
			pull = k == 8;
	end
endmodule

`default_nettype wire

// [tb/test_i2c_data_address_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module test_i2c_data_address_regs
	import i2c_regs_pkg::*;
;
	// ------------------------------
	// Bench state
	// ------------------------------
	logic              aclk    = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr  = 8'h00;
	logic [ADDR_W-1:0] araddr  = 8'h00;
	logic [31:0]       wdata   = 32'h0;
	logic              awvalid = 1'b0;
	logic              wvalid  = 1'b0;
	logic              bready  = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready  = 1'b0;
	logic [7:0]        tx_byte = 8'h00;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              scl_o, scl_oe, sda_o, sda_oe, pull, rx_stb;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata, last_rd, v;
	logic [7:0]        rx_byte, e_b;
	logic [65:0]       e_r;
	logic [65:0]       exp_r[$];
	logic [1:0]        exp_b[$];
	logic [7:0]        exp_bus[$];
	int                bad_count = 0;
	int                cmp_count = 0;
	int                cycles    = 0;
	int                seed;
	wire logic         scl_w;
	wire logic         sda_w;

	// Lines float high unless a party pulls them
	assign scl_w = !scl_oe || scl_o;
	assign sda_w = !pull && (!sda_oe || sda_o);

	always #5 aclk = !aclk;

	i2c_data_address_regs
	#(.HALF_BASE(2), .FIFO_DEPTH(8))
	i2c_data_address_regs_i
	(
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
	);

	i2c_bus_partner i2c_bus_partner_i
	(
		.scl(scl_w), .sda(sda_w), .tx_byte(tx_byte), .pull(pull),
		.rx_byte(rx_byte), .rx_stb(rx_stb)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic end_of_test;
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
	endtask

	// A zero mask notes a read whose data is not compared
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] w, input logic [1:0] r);
		@(posedge aclk);
		exp_r.push_back({r, m, w});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		last_rd = rdata;
		rready <= 1'b0;
	endtask

	task automatic wait_status(input int b, input logic want);
		do
			rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY);
		while (last_rd[b] !== want);
	endtask

	// Address byte, one data byte in the direction its bit 0 selects, stop while pending
	task automatic transmit(input logic [7:0] a, input logic [7:0] d);
		exp_bus.push_back(a);
		wr(OFF_SHIFT_BUF, {24'h0, a}, RESP_OKAY);
		wr(OFF_CONTROL_TWO, 32'h0000_00b8, RESP_OKAY);
		wait_status(SR_IDLE, 1'b0);
		if (a[DIR_BIT])
			rd(OFF_SHIFT_BUF, 32'h0, 32'h0, RESP_OKAY);
		else
		begin
			exp_bus.push_back(d);
			wr(OFF_SHIFT_BUF, {24'h0, d}, RESP_OKAY);
		end
		wait_status(SR_IDLE, 1'b0);
		wr(OFF_CONTROL_TWO, 32'h0000_00c8, RESP_OKAY);
		wait_status(SR_BUSY, 1'b0);
	endtask

	// Compare each answer with the oldest note
	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			e_r = exp_r.pop_front();
			check({30'h0, rresp}, {30'h0, e_r[65:64]});
			if (e_r[63:32] != 32'h0)
				check(rdata & e_r[63:32], e_r[31:0]);
		end
		if (bvalid && bready)
			check({30'h0, bresp}, {30'h0, exp_b.pop_front()});
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	always @(posedge rx_stb)
	begin
		e_b = exp_bus.size() > 0 ? exp_bus.pop_front() : 8'hxx;
		check({24'h0, rx_byte}, {24'h0, e_b});
	end

	initial
	begin
		seed = $urandom(32'hae8b_66cf);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values and unmapped places
		rd(OFF_CONTROL_ONE, 32'h0000_00ff, 32'h0, RESP_OKAY);
		rd(OFF_SHIFT_BUF, 32'h0000_00ff, 32'h0, RESP_OKAY);
		rd(OFF_OWN_ADDRESS, 32'h0000_00ff, 32'h0, RESP_OKAY);
		rd(8'h14, 32'h0, 32'h0, RESP_SLVERR);
		wr(8'h18, 32'h0, RESP_SLVERR);
		// Every rate code, random match-disable bit
		for (int c = 0; c < 8; c++)
		begin
			v = {28'h0, 1'($urandom), 3'(c)};
			wr(OFF_CONTROL_ONE, v, RESP_OKAY);
			rd(OFF_CONTROL_ONE, 32'h0000_000f, v, RESP_OKAY);
		end
		wr(OFF_CONTROL_ONE, 32'h0000_0001, RESP_OKAY);
		// Own address never zero; free format then addressed
		v = {24'h0, 7'($urandom | 1), 1'b1};
		wr(OFF_OWN_ADDRESS, v, RESP_OKAY);
		rd(OFF_OWN_ADDRESS, 32'h0000_00ff, v, RESP_OKAY);
		v[OA_FREE] = 1'b0;
		wr(OFF_OWN_ADDRESS, v, RESP_OKAY);
		rd(OFF_OWN_ADDRESS, 32'h0000_00ff, v, RESP_OKAY);
		// Master write, general call, master read
		transmit({7'($urandom), 1'b0}, 8'($urandom));
		transmit(GCALL_BYTE, 8'($urandom));
		tx_byte <= 8'($urandom);
		transmit({7'($urandom), 1'b1}, 8'h00);
		rd(OFF_SHIFT_BUF, 32'h0000_00ff, {24'h0, tx_byte}, RESP_OKAY);
		// Soft reset keeps the buffer byte
		wr(OFF_CONTROL_TWO, {30'h0, SWRES_ARM}, RESP_OKAY);
		wr(OFF_CONTROL_TWO, {30'h0, SWRES_FIRE}, RESP_OKAY);
		rd(OFF_SHIFT_BUF, 32'h0000_00ff, {24'h0, tx_byte}, RESP_OKAY);
		rd(OFF_OWN_ADDRESS, 32'h0000_00ff, v, RESP_OKAY);
		end_of_test();
	end
endmodule

bind i2c_data_address_regs i2c_data_address_regs_properties props_i
(
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .scl_oe(scl_oe)
);

`default_nettype wire
